// >>> inc/lcs_pkg.sv
package lcs_pkg;

    // register byte offsets
    localparam logic [7:0] LCS_OFS_CTRL = 8'h00;
    localparam logic [7:0] LCS_OFS_STAT = 8'h04;
    localparam logic [7:0] LCS_OFS_TBLF = 8'h08;
    localparam logic [7:0] LCS_OFS_TBLG = 8'h0C;
    localparam logic [7:0] LCS_OFS_HLUT = 8'h10;

    // control field positions, two-bit fields hold element 1 above element 0
    localparam int LCS_CTL_LATCH = 0;
    localparam int LCS_CTL_CKINV = 2;
    localparam int LCS_CTL_SETV = 4;
    localparam int LCS_CTL_GTIE = 6;
    localparam int LCS_CTL_SROPEN = 8;
    localparam int LCS_CTL_DSEL = 10;
    localparam int LCS_CTL_RAMF = 12;
    localparam int LCS_CTL_RAMG = 13;
    localparam int LCS_CTL_WIDE = 14;
    localparam int LCS_CTL_DUAL = 15;
    localparam int LCS_CTL_LEVEL = 16;
    localparam int LCS_CTL_RAMINV = 17;
    localparam int LCS_CTL_BITS = 18;

    // status field positions
    localparam int LCS_STA_Q = 0;
    localparam int LCS_STA_TF = 2;
    localparam int LCS_STA_TG = 3;
    localparam int LCS_STA_H = 4;

    // reset values
    localparam logic [31:0] LCS_CTRL_RST = 32'h0000_0000;
    localparam logic [7:0] LCS_HLUT_RST = 8'h00;
    localparam logic [1:0] LCS_Q_RST = 2'h0;

    // number of storage elements
    localparam int LCS_NELEM = 2;

endpackage

// >>> design/lcs_cell.sv
`timescale 1ns/1ps
module lcs_cell
    import lcs_pkg::*;
#(
    parameter int TBL_AW = 4,
    parameter int APB_AW = 8
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // fabric control inputs
    input wire logic cell_clk_i,
    input wire logic store_gate_i,
    input wire logic global_init_i,
    input wire logic first_aux_input_i,
    input wire logic second_aux_input_i,
    input wire logic third_aux_input_i,
    // table address inputs
    input wire logic [TBL_AW-1:0] primary_table_address_i,
    input wire logic [TBL_AW-1:0] second_table_address_i,
    // fabric outputs
    output logic [1:0] elem_q_o,
    output logic table_f_o,
    output logic table_g_o,
    output logic h_func_o
);

    localparam int DEPTH = 1 << TBL_AW;

    ////////////////////////////////////////////////////////////////////////
    // parameter checks
    generate
        if (TBL_AW < 1 || TBL_AW > 5) begin : g_bad_aw
            $error("table address width must be 1 to 5");
        end
        // register offsets are decoded from address bits 7 to 2
        if (APB_AW < 8) begin : g_bad_apb
            $error("apb address width must be at least 8");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [31:0] ctrl;
        logic [7:0] hlut;
        logic [DEPTH-1:0] tbl_f;
        logic [DEPTH-1:0] tbl_g;
        logic [1:0] q;
        logic clk_prev;
        logic tf_out;
        logic tg_out;
        logic h_out;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } lcs_state_t;

    lcs_state_t state_reg;
    lcs_state_t state_next;

    ////////////////////////////////////////////////////////////////////////
    // configuration decode
    logic [1:0] cfg_latch;
    logic [1:0] cfg_ckinv;
    logic [1:0] cfg_setv;
    logic [1:0] cfg_gtie;
    logic [1:0] cfg_sropen;
    logic [1:0] cfg_dsel;
    logic cfg_ramf;
    logic cfg_ramg;
    logic cfg_wide;
    logic cfg_dual;
    logic cfg_level;
    logic cfg_raminv;
    logic ram_any;

    // control word decoded once, every mode reads these nets
    // control register fields
    assign cfg_latch = state_reg.ctrl[LCS_CTL_LATCH +: 2];
    assign cfg_ckinv = state_reg.ctrl[LCS_CTL_CKINV +: 2];
    assign cfg_setv = state_reg.ctrl[LCS_CTL_SETV +: 2];
    assign cfg_gtie = state_reg.ctrl[LCS_CTL_GTIE +: 2];
    assign cfg_sropen = state_reg.ctrl[LCS_CTL_SROPEN +: 2];
    assign cfg_dsel = state_reg.ctrl[LCS_CTL_DSEL +: 2];
    assign cfg_ramf = state_reg.ctrl[LCS_CTL_RAMF];
    assign cfg_ramg = state_reg.ctrl[LCS_CTL_RAMG];
    assign cfg_wide = state_reg.ctrl[LCS_CTL_WIDE];
    assign cfg_dual = state_reg.ctrl[LCS_CTL_DUAL];
    assign cfg_level = state_reg.ctrl[LCS_CTL_LEVEL];
    assign cfg_raminv = state_reg.ctrl[LCS_CTL_RAMINV];
    assign ram_any = cfg_ramf | cfg_ramg;

    ////////////////////////////////////////////////////////////////////////
    // table read side, the same in every mode except wide, which changes the addressing
    logic [TBL_AW-1:0] addr_f;
    logic [TBL_AW-1:0] addr_g;
    logic rd_f;
    logic rd_g;
    logic rd_wide;
    logic out_f;
    logic h_val;

    // reads come straight from the stored bits and are registered once,
    // so every mode shows data one cycle after its address
    // wide mode reads both tables at the first address
    assign addr_f = primary_table_address_i;
    assign addr_g = cfg_wide ? primary_table_address_i : second_table_address_i;
    assign rd_f = state_reg.tbl_f[addr_f];
    assign rd_g = state_reg.tbl_g[addr_g];
    // fifth address bit picks the table in wide mode
    assign rd_wide = second_aux_input_i ? rd_g : rd_f;
    assign out_f = cfg_wide ? rd_wide : rd_f;
    // third generator combines both table outputs with one aux input
    assign h_val = state_reg.hlut[{second_aux_input_i, rd_g, rd_f}];

    ////////////////////////////////////////////////////////////////////////
    // storage elements
    logic [1:0] elem_q_next;

    genvar gi;
    generate
        for (gi = 0; gi < LCS_NELEM; gi++) begin : g_elem
            logic eclk;
            logic eclk_prev;
            logic erise;
            logic egate;
            logic esr;
            logic edata;

            // each element sees its own polarity of the shared clock
            assign eclk = cell_clk_i ^ cfg_ckinv[gi];
            assign eclk_prev = state_reg.clk_prev ^ cfg_ckinv[gi];
            // stored clock sample resets low, the idle level of the cell clock,
            // so no false edge follows reset
            assign erise = eclk & ~eclk_prev;
            // gate is active high; a tied gate is always on
            assign egate = store_gate_i | cfg_gtie[gi];
            // aux input turns into write enable in ram mode, then no preset/clear
            assign esr = third_aux_input_i & ~cfg_sropen[gi] & ~ram_any;
            // element loads the table output or the first aux input directly
            assign edata = cfg_dsel[gi] ? first_aux_input_i : (gi == 0 ? out_f : rd_g);

            // forced value wins, then latch or edge behaviour
            always_comb begin
                if (global_init_i || esr) begin
                    elem_q_next[gi] = cfg_setv[gi];
                end else if (cfg_latch[gi]) begin
                    if (!eclk && egate) begin
                        elem_q_next[gi] = edata;
                    end else begin
                        elem_q_next[gi] = state_reg.q[gi];
                    end
                end else if (erise && egate) begin
                    elem_q_next[gi] = edata;
                end else begin
                    elem_q_next[gi] = state_reg.q[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // table write side
    logic ram_clk;
    logic ram_clk_prev;
    logic ram_rise;
    logic wr_level;
    logic wr_strobe;
    logic wr_enable;
    logic data_a;
    logic data_b;

    // aux inputs take their ram meaning
    assign data_a = first_aux_input_i;
    assign data_b = second_aux_input_i;
    assign wr_enable = third_aux_input_i;
    // ram clock has its own inversion, apart from the two elements
    assign ram_clk = cell_clk_i ^ cfg_raminv;
    assign ram_clk_prev = state_reg.clk_prev ^ cfg_raminv;
    assign ram_rise = ram_clk & ~ram_clk_prev;
    // dual port runs edge timing only; one mode covers both tables
    assign wr_level = cfg_level & ~cfg_dual;
    // a level strobe writes in every cycle it stands, so address and data
    // must stay steady for the whole strobe
    // level timing writes while the strobe stands, edge timing on the clock
    assign wr_strobe = wr_level ? wr_enable : (wr_enable & ram_rise);

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic apb_req;
    logic apb_commit;
    logic [7:0] apb_ofs;
    logic apb_hit;
    logic [31:0] rd_mux;
    logic [31:0] stat_word;
    logic [APB_AW-1:0] apb_upper;

    // first access cycle latches the request, the one seeing pready commits;
    // the commit clears pready for one cycle, so a held access pulses it again every second cycle
    assign apb_req = psel_i & penable_i & ~state_reg.pready;
    assign apb_commit = psel_i & penable_i & state_reg.pready;
    assign apb_ofs = {paddr_i[7:2], 2'b00};
    // bits above the register window must be zero; a shift stays legal
    // when the bus is exactly eight bits wide
    assign apb_upper = paddr_i >> 8;
    assign apb_hit = (apb_upper == '0)
        && (apb_ofs == LCS_OFS_CTRL || apb_ofs == LCS_OFS_STAT
        || apb_ofs == LCS_OFS_TBLF || apb_ofs == LCS_OFS_TBLG
        || apb_ofs == LCS_OFS_HLUT);

    // status word shows the cell's live outputs
    // read-only; writes to it are dropped without an error
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[LCS_STA_Q +: 2] = state_reg.q;
        stat_word[LCS_STA_TF] = state_reg.tf_out;
        stat_word[LCS_STA_TG] = state_reg.tg_out;
        stat_word[LCS_STA_H] = state_reg.h_out;
    end

    // read data selection, unmapped reads give zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (apb_hit) begin
            unique case (apb_ofs)
                LCS_OFS_CTRL: rd_mux[LCS_CTL_BITS-1:0] = state_reg.ctrl[LCS_CTL_BITS-1:0];
                LCS_OFS_STAT: rd_mux = stat_word;
                LCS_OFS_TBLF: rd_mux[DEPTH-1:0] = state_reg.tbl_f;
                LCS_OFS_TBLG: rd_mux[DEPTH-1:0] = state_reg.tbl_g;
                LCS_OFS_HLUT: rd_mux[7:0] = state_reg.hlut;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // byte-lane merge of write data into a stored word
    function automatic logic [31:0] lcs_merge(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // next state
    logic [31:0] tf_word;
    logic [31:0] tg_word;
    logic [31:0] hl_word;
    logic [31:0] ct_word;

    always_comb begin
        state_next = state_reg;
        tf_word = 32'h0000_0000;
        tg_word = 32'h0000_0000;
        hl_word = 32'h0000_0000;
        ct_word = 32'h0000_0000;
        state_next.clk_prev = cell_clk_i;
        state_next.q = elem_q_next;
        state_next.tf_out = out_f;
        state_next.tg_out = rd_g;
        state_next.h_out = h_val;

        // fabric writes into the tables
        if (wr_strobe) begin
            // wide mode folds both tables into one store, the second data bit
            // naming the table
            if (cfg_wide) begin
                if (data_b) begin
                    if (cfg_ramg) begin
                        state_next.tbl_g[addr_f] = data_a;
                    end
                end else if (cfg_ramf) begin
                    state_next.tbl_f[addr_f] = data_a;
                end
            end else if (cfg_dual) begin
                // one write port at the first address, mirrored in both
                if (cfg_ramf && cfg_ramg) begin
                    state_next.tbl_f[addr_f] = data_a;
                    state_next.tbl_g[addr_f] = data_a;
                end
            end else begin
                // a table not in ram mode stays a fixed logic function
                if (cfg_ramf) begin
                    state_next.tbl_f[addr_f] = data_a;
                end
                if (cfg_ramg) begin
                    state_next.tbl_g[addr_g] = data_b;
                end
            end
        end

        // apb access phase: one wait cycle, then commit
        state_next.pready = apb_req;
        if (apb_req) begin
            state_next.prdata = pwrite_i ? 32'h0000_0000 : rd_mux;
            state_next.pslverr = ~apb_hit;
        end
        // software word is merged over a fabric write of the same cycle,
        // so the register write wins
        if (apb_commit && pwrite_i && apb_hit) begin
            unique case (apb_ofs)
                LCS_OFS_CTRL: begin
                    ct_word = lcs_merge(state_reg.ctrl, pwdata_i, pstrb_i);
                    state_next.ctrl = 32'h0000_0000;
                    state_next.ctrl[LCS_CTL_BITS-1:0] = ct_word[LCS_CTL_BITS-1:0];
                end
                LCS_OFS_TBLF: begin
                    tf_word[DEPTH-1:0] = state_next.tbl_f;
                    tf_word = lcs_merge(tf_word, pwdata_i, pstrb_i);
                    state_next.tbl_f = tf_word[DEPTH-1:0];
                end
                LCS_OFS_TBLG: begin
                    tg_word[DEPTH-1:0] = state_next.tbl_g;
                    tg_word = lcs_merge(tg_word, pwdata_i, pstrb_i);
                    state_next.tbl_g = tg_word[DEPTH-1:0];
                end
                LCS_OFS_HLUT: begin
                    hl_word[7:0] = state_reg.hlut;
                    hl_word = lcs_merge(hl_word, pwdata_i, pstrb_i);
                    state_next.hlut = hl_word[7:0];
                end
                default: begin
                    state_next.ctrl = state_reg.ctrl; // status is read-only
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    // tables and function bits start cleared, elements start in reset
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_reg.ctrl <= LCS_CTRL_RST;
            state_reg.hlut <= LCS_HLUT_RST;
            state_reg.tbl_f <= '0;
            state_reg.tbl_g <= '0;
            state_reg.q <= LCS_Q_RST;
            state_reg.clk_prev <= 1'b0;
            state_reg.tf_out <= 1'b0;
            state_reg.tg_out <= 1'b0;
            state_reg.h_out <= 1'b0;
            state_reg.prdata <= 32'h0000_0000;
            state_reg.pready <= 1'b0;
            state_reg.pslverr <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs from flip-flops
    assign prdata_o = state_reg.prdata;
    assign pready_o = state_reg.pready;
    assign pslverr_o = state_reg.pslverr;
    assign elem_q_o = state_reg.q;
    assign table_f_o = state_reg.tf_out;
    assign table_g_o = state_reg.tg_out;
    assign h_func_o = state_reg.h_out;

endmodule

// >>> verif/lcs_cell_chk.sv
`timescale 1ns/1ps
module lcs_cell_chk
    import lcs_pkg::*;
#(
    parameter int TBL_AW = 4,
    parameter int APB_AW = 8
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [APB_AW-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // fabric
    input wire logic cell_clk_i,
    input wire logic store_gate_i,
    input wire logic global_init_i,
    input wire logic first_aux_input_i,
    input wire logic second_aux_input_i,
    input wire logic third_aux_input_i,
    input wire logic [TBL_AW-1:0] primary_table_address_i,
    input wire logic [TBL_AW-1:0] second_table_address_i,
    input wire logic [1:0] elem_q_o,
    input wire logic table_f_o,
    input wire logic table_g_o,
    input wire logic h_func_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // no bus access and no clock, aux or table address input moving
    sequence quiet_s;
        !psel_i && $stable(cell_clk_i) && $stable(third_aux_input_i)
            && $stable(first_aux_input_i) && $stable(second_aux_input_i)
            && $stable(primary_table_address_i) && $stable(second_table_address_i);
    endsequence
    // init held while the bus stays idle
    sequence init_s;
        (global_init_i && !psel_i) [*2];
    endsequence
    ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("pready missing after access cycle");
    ready_idle_a: assert property (!(psel_i && penable_i) |=> !pready_o)
        else $error("pready without access cycle");
    ready_pulse_a: assert property (pready_o |=> !pready_o)
        else $error("pready longer than one cycle");
    write_zero_a: assert property (pready_o && $past(pwrite_i) |-> prdata_o == 32'h0)
        else $error("read data not zero on write");
    err_zero_a: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
        else $error("read data not zero on error");
    err_rise_a: assert property ($rose(pslverr_o) |-> pready_o)
        else $error("error rose outside a completion");
    reset_clear_a: assert property ($fell(srst_i) |-> elem_q_o == 2'h0 && !pready_o)
        else $error("outputs not cleared by reset");
    init_hold_a: assert property (init_s |=> $stable(elem_q_o))
        else $error("element output moved during init");
    table_hold_a: assert property (quiet_s [*3] |-> $stable({table_f_o, table_g_o, h_func_o}))
        else $error("table output moved with quiet inputs");
endmodule
bind lcs_cell lcs_cell_chk #(.TBL_AW(TBL_AW), .APB_AW(APB_AW)) u_chk (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .cell_clk_i(cell_clk_i), .store_gate_i(store_gate_i), .global_init_i(global_init_i),
    .first_aux_input_i(first_aux_input_i), .second_aux_input_i(second_aux_input_i),
    .third_aux_input_i(third_aux_input_i), .primary_table_address_i(primary_table_address_i),
    .second_table_address_i(second_table_address_i), .elem_q_o(elem_q_o),
    .table_f_o(table_f_o), .table_g_o(table_g_o), .h_func_o(h_func_o));

// >>> verif/lcs_fabric_model.sv
`timescale 1ns/1ps
module lcs_fabric_model
    import lcs_pkg::*;
(
    // clock
    input wire logic clk_sys_i,
    // user logic toward the cell
    output logic cell_clk_o,
    output logic store_gate_o,
    output logic global_init_o,
    output logic first_aux_o,
    output logic second_aux_o,
    output logic third_aux_o,
    output logic [3:0] addr_f_o,
    output logic [3:0] addr_g_o
);
    // idle fabric: clock low, strobe and init released
    initial begin
        {cell_clk_o, store_gate_o, global_init_o, first_aux_o, second_aux_o} = 5'h00;
        third_aux_o = 1'b0;
        addr_f_o = 4'h0;
        addr_g_o = 4'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one step: c = {clock, gate, init, data a, data b, strobe}, then settle
    // edge timing is the normal use, the level strobe only when asked
    task automatic put(input logic [5:0] c, input logic [3:0] af, input logic [3:0] ag);
        @(posedge clk_sys_i);
        {cell_clk_o, store_gate_o, global_init_o, first_aux_o, second_aux_o} <= c[5:1];
        third_aux_o <= c[0]; // strobe moves only with its address and data
        addr_f_o <= af;
        addr_g_o <= ag;
        repeat (3) @(posedge clk_sys_i);
    endtask
endmodule

// >>> verif/test_logic_cell_storage_and_ram.sv
`timescale 1ns/1ps
module test_logic_cell_storage_and_ram;
    import lcs_pkg::*;
    localparam logic [31:0] DSEL = 32'h3 << LCS_CTL_DSEL;
    localparam logic [31:0] RAM = 32'h3 << LCS_CTL_RAMF;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, err, ck, gate, ginit, aux_a, aux_b, aux_c, tf, tg, hf;
    logic [3:0] adr_f, adr_g;
    logic [1:0] q;
    int err_count = 0;
    int n_compared = 0;
    // free-running system clock
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    lcs_cell #(.TBL_AW(4), .APB_AW(8)) dut (.clk_sys_i(clk_sys), .srst_i(srst),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .cell_clk_i(ck), .store_gate_i(gate), .global_init_i(ginit),
        .first_aux_input_i(aux_a), .second_aux_input_i(aux_b), .third_aux_input_i(aux_c),
        .primary_table_address_i(adr_f), .second_table_address_i(adr_g),
        .elem_q_o(q), .table_f_o(tf), .table_g_o(tg), .h_func_o(hf));
    lcs_fabric_model fab (.clk_sys_i(clk_sys), .cell_clk_o(ck), .store_gate_o(gate),
        .global_init_o(ginit), .first_aux_o(aux_a), .second_aux_o(aux_b),
        .third_aux_o(aux_c), .addr_f_o(adr_f), .addr_g_o(adr_g));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // one comparison
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one apb transfer, answer taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            check("bus wait", 32'h1, 32'h0);
            stop_test();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask
    // element outputs and table outputs {g, f}
    task automatic qchk(input string what, input logic [1:0] e);
        check(what, {30'h0, e}, {30'h0, q});
    endtask
    task automatic tchk(input string what, input logic [1:0] e);
        check(what, {30'h0, e}, {30'h0, tg, tf});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        rd_chk("ctrl", LCS_OFS_CTRL, LCS_CTRL_RST);
        rd_chk("stat", LCS_OFS_STAT, 32'h0);
        apb(1'b1, LCS_OFS_HLUT, 32'hA5);
        apb(1'b1, LCS_OFS_STAT, 32'h1F);
        rd_chk("hlut", LCS_OFS_HLUT, 32'hA5);
        rd_chk("stat h", LCS_OFS_STAT, 32'h10);
        check("h func", 32'h1, {31'h0, hf});
        apb(1'b0, 8'h14, 32'h0);
        check("unmapped", 32'h1, {31'h0, err});
        $display("test registers done");
        apb(1'b1, LCS_OFS_CTRL, DSEL);
        fab.put(6'h14, 4'h0, 4'h0);
        fab.put(6'h34, 4'h0, 4'h0);
        qchk("ff load", 2'h3);
        fab.put(6'h00, 4'h0, 4'h0);
        fab.put(6'h20, 4'h0, 4'h0);
        qchk("gate low", 2'h3);
        fab.put(6'h01, 4'h0, 4'h0);
        qchk("preset", 2'h0);
        fab.put(6'h00, 4'h0, 4'h0);
        apb(1'b1, LCS_OFS_CTRL, DSEL | (32'h1 << LCS_CTL_CKINV));
        fab.put(6'h34, 4'h0, 4'h0);
        qchk("rise only", 2'h2);
        fab.put(6'h14, 4'h0, 4'h0);
        qchk("fall elem", 2'h3);
        apb(1'b1, LCS_OFS_CTRL, DSEL | (32'h3 << LCS_CTL_GTIE) | (32'h3 << LCS_CTL_SROPEN)
            | (32'h3 << LCS_CTL_SETV));
        fab.put(6'h00, 4'h0, 4'h0);
        fab.put(6'h20, 4'h0, 4'h0);
        qchk("gate tied", 2'h0);
        fab.put(6'h01, 4'h0, 4'h0);
        qchk("open preset", 2'h0);
        fab.put(6'h08, 4'h0, 4'h0);
        qchk("init set", 2'h3);
        apb(1'b1, LCS_OFS_CTRL, DSEL | (32'h3 << LCS_CTL_LATCH));
        fab.put(6'h10, 4'h0, 4'h0);
        qchk("latch open", 2'h0);
        fab.put(6'h14, 4'h0, 4'h0);
        qchk("latch follow", 2'h3);
        fab.put(6'h30, 4'h0, 4'h0);
        qchk("latch hold", 2'h3);
        $display("test elements done");
        apb(1'b1, LCS_OFS_CTRL, RAM);
        fab.put(6'h05, 4'h5, 4'h9);
        tchk("no edge", 2'h0);
        fab.put(6'h25, 4'h5, 4'h9);
        fab.put(6'h00, 4'h5, 4'h9);
        tchk("edge write", 2'h1);
        rd_chk("tblf", LCS_OFS_TBLF, 32'h20);
        fab.put(6'h00, 4'h6, 4'h9);
        tchk("other cell", 2'h0);
        apb(1'b1, LCS_OFS_CTRL, RAM | (32'h1 << LCS_CTL_LEVEL));
        fab.put(6'h07, 4'h2, 4'h3);
        fab.put(6'h00, 4'h2, 4'h3);
        tchk("level write", 2'h3);
        apb(1'b1, LCS_OFS_CTRL, RAM | (32'h1 << LCS_CTL_WIDE));
        fab.put(6'h07, 4'h4, 4'h0);
        fab.put(6'h27, 4'h4, 4'h0);
        fab.put(6'h02, 4'h4, 4'h0);
        check("wide upper", 32'h1, {31'h0, tf});
        fab.put(6'h00, 4'h4, 4'h0);
        check("wide lower", 32'h0, {31'h0, tf});
        apb(1'b1, LCS_OFS_CTRL, RAM | (32'h1 << LCS_CTL_DUAL));
        fab.put(6'h05, 4'hA, 4'h0);
        fab.put(6'h25, 4'hA, 4'hA);
        fab.put(6'h00, 4'h0, 4'hA);
        tchk("dual read", 2'h2);
        fab.put(6'h00, 4'hA, 4'hA);
        tchk("dual both", 2'h3);
        check("h dual", 32'h0, {31'h0, hf});
        fab.put(6'h30, 4'h0, 4'hA);
        qchk("table load", 2'h2);
        $display("test tables done");
        fab.put(6'h00, 4'h0, 4'h0);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        qchk("reset elems", 2'h0);
        tchk("reset tables", 2'h0);
        $display("test reset done");
        stop_test();
    end
endmodule
